// file: src/adc_seq_pkg.sv
// Constants shared by the conversion sequencer, its step timer and the test bench.
// Assumes a single system clock of 50 MHz and a 32-bit classic Wishbone register bus.
package adc_seq_pkg;
    localparam int          NUM_CHANNELS     = 8;
    localparam int          CHAN_W           = 3;
    localparam int          RESULT_W         = 10;
    localparam int          NUM_STEPS        = 13;
    localparam int          STEP_DIV         = 16;
    localparam int          PHASE_W          = 8;
    localparam int          ADDR_W           = 4;
    // Register byte addresses.
    localparam logic [3:0]  ADDR_CTRL        = 4'h0;
    localparam logic [3:0]  ADDR_TIMING      = 4'h4;
    localparam logic [3:0]  ADDR_RESULT      = 4'h8;
    localparam logic [3:0]  ADDR_IRQ_STATUS  = 4'hc;
    // Control register fields.
    localparam int          CTRL_START_BIT   = 0;
    localparam int          CTRL_BUSY_BIT    = 1;
    localparam int          CTRL_EXTREF_BIT  = 2;
    localparam int          CTRL_CHAN_LSB    = 4;
    localparam int          CTRL_IRQ_MASK_BIT = 8;
    // Timing register fields.
    localparam int          TIMING_SAMPLE_LSB = 0;
    localparam int          TIMING_HOLD_LSB  = 8;
    // Reset values of the phase counts and the channel select.
    localparam logic [7:0]  SAMPLE_RESET     = 8'h14;
    localparam logic [7:0]  HOLD_RESET       = 8'h0a;
    localparam logic [2:0]  CHAN_RESET       = 3'h0;
endpackage

// file: src/adc_step_if.sv
// Interface between the sequencer and its step timer.
// Assumes both ends run on the same system clock.
`timescale 1ns/100ps
interface adc_step_if;
    logic start;
    logic step_tick;
    logic last_step;
    logic [3:0] step_index;
    modport ctrl  (output start, input step_tick, input last_step, input step_index);
    modport timer (input start, output step_tick, output last_step, output step_index);
endinterface

// file: src/adc_step_timer.sv
// Step timer: divides the system clock by a fixed 16 and counts the conversion steps.
// Assumes start is a one-cycle pulse; a start that comes while the timer runs restarts it from step 0.
`timescale 1ns/100ps
module adc_step_timer
    import adc_seq_pkg::*;
(
    // Clock and reset.
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Sequencer side.
    adc_step_if.timer step
);
    typedef struct packed {
        logic       run;
        logic [3:0] div;
        logic [3:0] index;
        logic       tick;
        logic       last;
    } timer_state_t;

    timer_state_t state_reg;
    timer_state_t state_next;

    always_comb begin
        state_next      = state_reg;
        state_next.tick = 1'b0;
        state_next.last = 1'b0;
        if (step.start) begin
            state_next.run   = 1'b1;
            state_next.div   = 4'h0;
            state_next.index = 4'h0;
        end else if (state_reg.run) begin
            // Fixed divide by 16, not software programmable.
            if (state_reg.div == 4'(STEP_DIV - 1)) begin
                state_next.div  = 4'h0;
                state_next.tick = 1'b1;
                if (state_reg.index == 4'(NUM_STEPS - 1)) begin
                    state_next.last = 1'b1;
                    state_next.run  = 1'b0;
                end else begin
                    state_next.index = state_reg.index + 4'h1;
                end
            end else begin
                state_next.div = state_reg.div + 4'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign step.step_tick  = state_reg.tick;
    assign step.last_step  = state_reg.last;
    assign step.step_index = state_reg.index;
endmodule

// file: src/sar_adc_conversion_sequencer.sv
// Conversion sequencer for an eight-input successive-approximation converter.
// Assumes a classic Wishbone master and an analog core whose comparator output is synchronous.
// Summary of operation
// - Exactly one of eight inputs is routed to the converter by the channel select.
// - Each conversion yields an unsigned ten-bit result.
// - The result is written into the result register at the end of every conversion.
// - An interrupt is raised when a conversion finishes and its result is stored.
// - Duration is sample plus hold plus 13 steps of 16 clocks each.
// - Sample and hold lengths are separate programmable counts of system clocks.
// - A setting chooses internal or external reference voltage.
`timescale 1ns/100ps
module sar_adc_conversion_sequencer
    import adc_seq_pkg::*;
(
    // Clock and reset.
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    // Wishbone slave.
    input  wire logic                    cyc_i,
    input  wire logic                    stb_i,
    input  wire logic                    we_i,
    input  wire logic [ADDR_W-1:0]       adr_i,
    input  wire logic [3:0]              sel_i,
    input  wire logic [31:0]             dat_i,
    output logic      [31:0]             dat_o,
    output logic                         ack_o,
    // Analog core.
    output logic      [NUM_CHANNELS-1:0] chan_enable_o,
    output logic                         sample_o,
    output logic                         ext_ref_o,
    output logic      [RESULT_W-1:0]     dac_code_o,
    input  wire logic                    comp_i,
    // Interrupt.
    output logic                         irq_o
);
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SAMPLE,
        ST_HOLD,
        ST_CONVERT
    } phase_t;

    typedef struct packed {
        phase_t                phase;
        logic [PHASE_W-1:0]    count;
        logic [CHAN_W-1:0]     chan;
        logic                  ext_ref;
        logic [PHASE_W-1:0]    sample_clocks;
        logic [PHASE_W-1:0]    hold_clocks;
        logic                  irq_mask;
        logic                  irq_status;
        logic [RESULT_W-1:0]   trial;
        logic [RESULT_W-1:0]   result;
        logic                  start_pulse;
        logic [NUM_CHANNELS-1:0] chan_en;
        logic                  sample;
        logic                  irq;
        logic                  ack;
        logic [31:0]           rdata;
        logic [RESULT_W-1:0]   dac_code;
    } seq_state_t;

    seq_state_t state_reg;
    seq_state_t state_next;

    adc_step_if step ();

    adc_step_timer u_step_timer (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .step  (step.timer)
    );

    logic                bus_req;
    logic                bus_wr;
    logic                busy;
    logic [31:0]         ctrl_view;
    logic [RESULT_W-1:0] bit_mask;
    logic [RESULT_W-1:0] tick_mask;

    assign bus_req   = cyc_i && stb_i && !state_reg.ack;
    assign bus_wr    = bus_req && we_i && sel_i[0];
    assign busy      = state_reg.phase != ST_IDLE;
    assign step.start = state_reg.start_pulse;
    assign bit_mask  = RESULT_W'(10'h200 >> step.step_index);
    // The timer has already stepped on when its tick shows, so the bit just tried sits one place higher.
    assign tick_mask = RESULT_W'(11'h400 >> step.step_index);

    always_comb begin
        ctrl_view                    = '0;
        ctrl_view[CTRL_BUSY_BIT]     = busy;
        ctrl_view[CTRL_EXTREF_BIT]   = state_reg.ext_ref;
        ctrl_view[CTRL_CHAN_LSB +: CHAN_W] = state_reg.chan;
        ctrl_view[CTRL_IRQ_MASK_BIT] = state_reg.irq_mask;
    end

    always_comb begin
        state_next             = state_reg;
        state_next.start_pulse = 1'b0;
        state_next.ack         = bus_req;
        state_next.rdata       = '0;

        // Register reads.
        if (bus_req && !we_i) begin
            unique case (adr_i)
                ADDR_CTRL:       state_next.rdata = ctrl_view;
                ADDR_TIMING:     state_next.rdata = {16'h0, state_reg.hold_clocks, state_reg.sample_clocks};
                ADDR_RESULT:     state_next.rdata = {22'h0, state_reg.result};
                ADDR_IRQ_STATUS: state_next.rdata = {31'h0, state_reg.irq_status};
                default:         state_next.rdata = '0;
            endcase
        end

        // Register writes; channel, reference and timing are locked while a conversion runs.
        if (bus_wr) begin
            unique case (adr_i)
                ADDR_CTRL: begin
                    if (sel_i[1]) begin
                        state_next.irq_mask = dat_i[CTRL_IRQ_MASK_BIT];
                    end
                    if (!busy) begin
                        state_next.ext_ref = dat_i[CTRL_EXTREF_BIT];
                        state_next.chan    = dat_i[CTRL_CHAN_LSB +: CHAN_W];
                        state_next.start_pulse = dat_i[CTRL_START_BIT];
                    end
                end
                ADDR_TIMING: begin
                    if (!busy) begin
                        state_next.sample_clocks = dat_i[TIMING_SAMPLE_LSB +: PHASE_W];
                        if (sel_i[1]) begin
                            state_next.hold_clocks = dat_i[TIMING_HOLD_LSB +: PHASE_W];
                        end
                    end
                end
                ADDR_IRQ_STATUS: begin
                    if (dat_i[0]) begin
                        state_next.irq_status = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        // Conversion sequence: sample, hold, then 13 divided steps.
        unique case (state_reg.phase)
            ST_IDLE: begin
                if (state_reg.start_pulse) begin
                    state_next.phase = ST_SAMPLE;
                    state_next.count = state_reg.sample_clocks;
                end
            end
            ST_SAMPLE: begin
                if (state_reg.count <= 8'h1) begin
                    state_next.phase = ST_HOLD;
                    state_next.count = state_reg.hold_clocks;
                end else begin
                    state_next.count = state_reg.count - 8'h1;
                end
            end
            ST_HOLD: begin
                if (state_reg.count <= 8'h1) begin
                    state_next.phase = ST_CONVERT;
                    state_next.trial = '0;
                end else begin
                    state_next.count = state_reg.count - 8'h1;
                end
            end
            ST_CONVERT: begin
                // Steps 0..9 resolve one bit each, MSB first; the rest settle.
                if (step.step_tick && step.step_index <= 4'(RESULT_W)) begin
                    if (comp_i) begin
                        state_next.trial = state_reg.trial | tick_mask;
                    end
                end
                if (step.last_step) begin
                    state_next.result     = state_reg.trial;
                    state_next.irq_status = 1'b1;
                    state_next.phase      = ST_IDLE;
                end
            end
        endcase

        // Kick the step timer as the hold phase ends.
        if (state_reg.phase == ST_HOLD && state_reg.count <= 8'h1) begin
            state_next.start_pulse = 1'b1;
        end

        state_next.chan_en = '0;
        state_next.chan_en[state_next.chan] = 1'b1;
        state_next.sample  = state_next.phase == ST_SAMPLE;
        state_next.irq     = state_next.irq_status && state_next.irq_mask;
        // Trial code shows the bit under test on top of those already kept.
        state_next.dac_code = state_next.trial | ((state_next.phase == ST_CONVERT) ? bit_mask : 10'h000);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg               <= '0;
            state_reg.phase         <= ST_IDLE;
            state_reg.chan          <= CHAN_RESET;
            state_reg.sample_clocks <= SAMPLE_RESET;
            state_reg.hold_clocks   <= HOLD_RESET;
            state_reg.chan_en       <= 8'h01;
        end else begin
            state_reg <= state_next;
        end
    end

    assign dat_o         = state_reg.rdata;
    assign dac_code_o    = state_reg.dac_code;
    assign ack_o         = state_reg.ack;
    assign chan_enable_o = state_reg.chan_en;
    assign sample_o      = state_reg.sample;
    assign ext_ref_o     = state_reg.ext_ref;
    assign irq_o         = state_reg.irq;
endmodule

// file: tb/adc_core_model.sv
// Analog core model: one fixed level per input, compared with the trial code.
// Assumes comp_o is read by the sequencer on its step edges.
`timescale 1ns/100ps
module adc_core_model
    import adc_seq_pkg::*;
(
    // Sequencer side.
    input  wire logic [NUM_CHANNELS-1:0] chan_enable_i,
    input  wire logic                    ext_ref_i,
    input  wire logic [RESULT_W-1:0]     dac_code_i,
    output logic                         comp_o
);
    // The external reference is taken as twice the internal one.
    function automatic logic [9:0] level(input int ch, input logic ext);
        logic [9:0] v;
        v = 10'h3ff - 10'(ch) * 10'h092;
        return ext ? v >> 1 : v;
    endfunction

    always_comb begin
        comp_o = 1'b0;
        for (int i = 0; i < NUM_CHANNELS; i++) begin
            if (chan_enable_i[i]) begin
                comp_o = level(i, ext_ref_i) >= dac_code_i;
            end
        end
    end
endmodule

// file: tb/sar_adc_conversion_sequencer_monitor.sv
// Port checker for the conversion sequencer.
// Assumes it is bound to the top module and sees its ports only.
`timescale 1ns/100ps
module sar_adc_conversion_sequencer_monitor
    import adc_seq_pkg::*;
(
    // Observed ports.
    input wire logic                    clk_i,
    input wire logic                    rst_i,
    input wire logic                    cyc_i,
    input wire logic                    stb_i,
    input wire logic [31:0]             dat_o,
    input wire logic                    ack_o,
    input wire logic [NUM_CHANNELS-1:0] chan_enable_o,
    input wire logic                    sample_o,
    input wire logic                    ext_ref_o,
    input wire logic                    irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [8:0] since_sample;

    always_ff @(posedge clk_i) begin
        if (rst_i) since_sample <= 9'h1ff;
        else if (sample_o) since_sample <= 9'h000;
        else if (since_sample != 9'h1ff) since_sample <= since_sample + 9'h001;
    end

    a_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    a_ack_prompt: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not answered in one cycle");
    a_ack_cause: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
        else $error("ack without a request");
    a_dat_idle: assert property (!ack_o |-> dat_o == 32'h0)
        else $error("read data not zero outside ack");
    a_chan_onehot: assert property ($onehot(chan_enable_o))
        else $error("channel select not one-hot");
    a_cfg_locked: assert property (sample_o && $past(sample_o) |-> $stable(chan_enable_o) && $stable(ext_ref_o))
        else $error("setup changed while sampling");
    a_reset_vals: assert property ($fell(rst_i) |-> chan_enable_o == 8'h01 && !ack_o && !irq_o && !sample_o)
        else $error("outputs not at reset values");
    a_conv_length: assert property ($rose(irq_o) |-> since_sample >= 9'd208)
        else $error("conversion ended too early");
endmodule

// file: tb/test_sar_adc_conversion_sequencer.sv
// Self-checking bench for the conversion sequencer.
// Assumes the analog core model and the port checker in tb/.
`timescale 1ns/100ps
module test_sar_adc_conversion_sequencer
    import adc_seq_pkg::*;
;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i = 1'b0;
    logic [3:0]  adr_i = 4'h0;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic [31:0] rd;
    logic        ack_o;
    logic        sample_o;
    logic        ext_ref_o;
    logic        comp_i;
    logic        irq_o;
    logic [7:0]  chan_enable_o;
    logic [9:0]  dac_code_o;
    int          n_fail = 0;
    int          n_tests = 0;
    int          cycles = 0;
    int          t0;
    int          t1;

    sar_adc_conversion_sequencer i_sar_adc_conversion_sequencer (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .chan_enable_o(chan_enable_o), .sample_o(sample_o), .ext_ref_o(ext_ref_o), .dac_code_o(dac_code_o),
        .comp_i(comp_i), .irq_o(irq_o));
    adc_core_model i_adc_core_model (.chan_enable_i(chan_enable_o), .ext_ref_i(ext_ref_o),
        .dac_code_i(dac_code_o), .comp_o(comp_i));

    initial forever #10 clk_i = ~clk_i;

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= we;
        adr_i <= adr;
        sel_i <= 4'hf;
        dat_i <= dat;
        while (ack_o !== 1'b1) @(posedge clk_i);
        rd = dat_o;
        check("bus ack", 32'h1, {31'h0, ack_o});
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask

    // Wait up to n cycles for the interrupt line to reach the given level.
    task automatic wait_irq(input logic lvl, input int n, output int t);
        for (t = 0; t < n && irq_o !== lvl; t++) @(posedge clk_i);
        check("irq", {31'h0, lvl}, {31'h0, irq_o});
    endtask

    task automatic convert(input int ch, input logic ext, input logic [7:0] s, input logic [7:0] h,
                           input logic mask, output int t);
        int lo;
        lo = (s == 0 ? 1 : s) + (h == 0 ? 1 : h) + 208;
        wb(1'b1, ADDR_TIMING, {16'h0, h, s});
        wb(1'b1, ADDR_CTRL, {23'h0, mask, 1'b0, 3'(ch), 1'b0, ext, 2'b01});
        check("channel", 32'h1 << ch, {24'h0, chan_enable_o});
        wb(1'b0, ADDR_CTRL, 32'h0);
        check("busy", 32'h1, {31'h0, rd[1]});
        if (mask) begin
            wait_irq(1'b1, 900, t);
        end else begin
            // Masked: let the conversion run out, the line must stay low.
            repeat (lo + 8) @(posedge clk_i);
            wait_irq(1'b0, 1, t);
        end
        if (mask) check("duration", 32'h1, {31'h0, t >= lo - 4 && t <= lo + 2});
        check("reference", {31'h0, ext}, {31'h0, ext_ref_o});
        wb(1'b0, ADDR_RESULT, 32'h0);
        check("result", {22'h0, i_adc_core_model.level(ch, ext)}, rd);
        wb(1'b0, ADDR_CTRL, 32'h0);
        check("busy clear", 32'h0, {31'h0, rd[1]});
        wb(1'b0, ADDR_IRQ_STATUS, 32'h0);
        check("done flag", 32'h1, rd);
        wb(1'b1, ADDR_CTRL, {23'h1, 8'h0});
        wait_irq(1'b1, 3, lo);
        wb(1'b1, ADDR_IRQ_STATUS, 32'h1);
        wait_irq(1'b0, 3, lo);
    endtask

    // Setup written in mid-conversion must be ignored.
    task automatic t_locked();
        wb(1'b1, ADDR_CTRL, {23'h1, 8'h21});
        wb(1'b1, ADDR_CTRL, {23'h1, 8'h55});
        check("locked channel", 32'h4, {24'h0, chan_enable_o});
        check("locked reference", 32'h0, {31'h0, ext_ref_o});
        wait_irq(1'b1, 900, t1);
        wb(1'b1, ADDR_IRQ_STATUS, 32'h1);
        wb(1'b0, 4'h6, 32'h0);
        check("unmapped", 32'h0, rd);
    endtask

    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, ADDR_CTRL, 32'h0);
        check("ctrl reset", 32'h0, rd);
        wb(1'b0, ADDR_TIMING, 32'h0);
        check("timing reset", 32'h0a14, rd);
        for (int ch = 0; ch < NUM_CHANNELS; ch++) convert(ch, 1'b0, 8'd20, 8'd10, 1'b1, t0);
        convert(3, 1'b1, 8'd50, 8'd3, 1'b1, t1);
        check("duration step", 32'd23, 32'(t1 - t0));
        convert(7, 1'b0, 8'd0, 8'd0, 1'b0, t1);
        t_locked();
        give_verdict();
    end
endmodule

bind sar_adc_conversion_sequencer sar_adc_conversion_sequencer_monitor i_mon (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .chan_enable_o(chan_enable_o),
    .sample_o(sample_o), .ext_ref_o(ext_ref_o), .irq_o(irq_o));
